// ---- hdl/vir_pkg.sv ----
// package: constants and types for the interrupt vector and swap ram register bank
// Function
// [R01] level 3 code in bits 4:2 picks request line 4..7 and priority 14..17.
// [R02] level 3 code lsb picks interrupter type: even acknowledge-release, odd register-release.
// [R03] config bit 1 picks level 2 interrupter type; resets to zero.
// [R04] level 2 always uses request line 4 at priority 14.
// [R05] config bit 0 picks level 1 interrupter type; level 1 fixed on line 4.
// [R06] offset bits 15:8 joined with returned vme vector answer identify for that interrupter.
// [R07] offset register bits 31:16 and 7 read zero and ignore writes.
// [R08] software sets test-fail bit 6; device clears it when all tests pass.
// [R09] diagnostic-mode bit 5 puts the device in loopback; resets to zero.
// [R10] disable-vme bit 4 turns off vme bus drivers.
// [R11] bits 3:0 internal bus mask: host read-only, internal bus writable, reset zero.
// [R12] vector register bits 31:16 select every targeted system node for interrupt transactions.
// [R13] vector bits 15:2 answer identify only for own error interrupts.
// [R14] vector register bits 1:0 are plain read/write diagnostic bits.
// [R15] swap ram access port maps to a 64k by 4 page ram.
// [R16] write with bit 4 set stores bits 2:0 at the decoded page address.
// [R17] write with bit 4 clear applies address only; next read returns entry bits 2:0.
// [R18] page size 00 uses bits 27:12, 01 bits 28:13, 10 bits 24:9.
// [R19] access port bits 31:29 and 8:5 read zero.
// [R20] ram write stores even parity in bit 3; read returns it with data.
// [R21] page rmw bit set gives normal reads, clear gives interlocked reads.
// [R22] page swap code: 00 none, 01 byte, 10 word, 11 longword.
// [R23] access port read without prior address write returns last applied address entry.
package vir_pkg;
    // register offsets in nodespace
    localparam logic [7:0]  VIR_OFS_LVL_CFG   = 8'h4C;
    localparam logic [7:0]  VIR_OFS_VEC_OFS   = 8'h50;
    localparam logic [7:0]  VIR_OFS_VEC_DEST  = 8'h54;
    localparam logic [7:0]  VIR_OFS_SWAP_RAM  = 8'h58;
    // interrupt_level_config fields
    localparam int          VIR_LVL3_LSB      = 2;
    localparam int          VIR_LVL2_BIT      = 1;
    localparam int          VIR_LVL1_BIT      = 0;
    localparam logic [4:0]  VIR_LVL_CFG_MASK  = 5'h1F;
    // vector_offset_diag_ctrl fields
    localparam int          VIR_VOFS_LSB      = 8;
    localparam int          VIR_FAIL_BIT      = 6;
    localparam int          VIR_DIAG_BIT      = 5;
    localparam int          VIR_VDIS_BIT      = 4;
    localparam int          VIR_IBMASK_W      = 4;
    // interrupt_vector_dest fields
    localparam int          VIR_DEST_LSB      = 16;
    localparam int          VIR_VEC_LSB       = 2;
    // swap_ram_access_port fields
    localparam int          VIR_RAR_RW_BIT    = 4;
    localparam int          VIR_RAR_PAR_BIT   = 3;
    localparam int          VIR_PG4K_LSB      = 12;
    localparam int          VIR_PG8K_LSB      = 13;
    localparam int          VIR_PG512_LSB     = 9;
    localparam logic [1:0]  VIR_PG_4K         = 2'h0;
    localparam logic [1:0]  VIR_PG_8K         = 2'h1;
    localparam logic [1:0]  VIR_PG_512        = 2'h2;
    // ram geometry
    localparam int          VIR_RAM_AW        = 16;
    localparam int          VIR_RAM_DW        = 4;
    // priority level of request line code 0
    localparam logic [4:0]  VIR_PRIO_BASE     = 5'h0E;
    // reset values
    localparam logic [31:0] VIR_RST_WORD      = 32'h0000_0000;

    // bus request line, code value is line number minus four
    typedef enum logic [1:0] {VIR_BR4 = 2'h0, VIR_BR5 = 2'h1, VIR_BR6 = 2'h2, VIR_BR7 = 2'h3} vir_brline_t;
    typedef enum logic [1:0] {VIR_SW_NONE = 2'h0, VIR_SW_BYTE = 2'h1,
                              VIR_SW_WORD = 2'h2, VIR_SW_LONG = 2'h3} vir_swap_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } vir_reg_req_t;

    typedef struct packed {
        logic        parity;
        logic        rmw_normal;
        vir_swap_t   swap;
    } vir_page_attr_t;
endpackage

// ---- hdl/vir_page_ram.sv ----
// module: 64k by 4 page attribute ram, host port and vme lookup port
`timescale 1ns/100ps
module vir_page_ram
    import vir_pkg::*;
#(
    parameter int AW = VIR_RAM_AW
) (
    // clock
    input  wire logic          ref_clk,
    // host port
    input  wire logic          host_en,
    input  wire logic          host_we,
    input  wire logic [AW-1:0] host_addr,
    input  wire logic [2:0]    host_wdata,
    output logic [3:0]         host_rdata,
    // vme lookup port
    input  wire logic          look_en,
    input  wire logic [AW-1:0] look_addr,
    output logic [3:0]         look_rdata
);
    // contents power up undefined, as the page table does
    logic [3:0] mem [0:(1<<AW)-1];

    always_ff @(posedge ref_clk) begin
        if (host_en) begin
            if (host_we) begin
                // even parity: the stored nibble always carries an even count of ones
                mem[host_addr] <= {^host_wdata, host_wdata}; // [R20]
                host_rdata     <= {^host_wdata, host_wdata}; // [R20]
            end else begin
                host_rdata <= mem[host_addr]; // [R17]
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (look_en) begin
            look_rdata <= mem[look_addr];
        end
    end
endmodule

// ---- hdl/vir_regs.sv ----
// module: interrupt level config, vector registers and swap ram access port
`timescale 1ns/100ps
module vir_regs
    import vir_pkg::*;
(
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst,
    // host register port in nodespace
    input  wire vir_reg_req_t  reg_req,
    output logic [31:0]        reg_rdata,
    output logic               reg_rvalid,
    // internal bus diagnostic mask write
    input  wire logic          internal_bus_mask_we,
    input  wire logic [3:0]    internal_bus_mask_wdata,
    // diagnostic sequencer and device configuration
    input  wire logic          diag_all_passed,
    input  wire logic [1:0]    page_size_code,
    // vme interrupt acknowledge capture
    input  wire logic          iack_done,
    input  wire logic [1:0]    iack_level,
    input  wire logic [7:0]    iack_vector,
    // identify request from system bus
    input  wire logic          ident_req,
    input  wire logic          ident_own,
    input  wire logic [1:0]    ident_level,
    output logic [15:0]        ident_vector,
    output logic               ident_valid,
    // interrupt routing per level, index 0 is level 1
    output vir_brline_t [2:0]  lvl_brline,
    output logic [2:0][4:0]    lvl_priority_level,
    output logic [2:0]         lvl_rora,
    output logic [15:0]        interrupt_transaction_dest,
    // diagnostic controls
    output logic               loopback_en,
    output logic               vme_drv_disable,
    // vme page lookup
    input  wire logic          look_req,
    input  wire logic [15:0]   look_page,
    output logic               look_valid,
    output logic               look_interlock,
    output vir_swap_t          look_swap,
    output logic               look_parity_err
);
    logic [4:0]  lvl_cfg_q;
    logic [7:0]  vofs_q;
    logic        fail_q;
    logic        diag_q;
    logic        vdis_q;
    logic [3:0]  ibmask_q;
    logic [31:0] vvr_q;
    logic [7:0]  iack_vec_q [0:2];
    logic        look_pend_q;
    logic [3:0]  ram_host_rd;
    logic [3:0]  ram_look_rd;
    logic [15:0] ram_addr_d;
    logic        wr_lvl;
    logic        wr_vofs;
    logic        wr_vvr;
    logic        wr_rar;
    logic [31:0] rd_word_d;

    assign wr_lvl  = reg_req.wr && (reg_req.addr == VIR_OFS_LVL_CFG);
    assign wr_vofs = reg_req.wr && (reg_req.addr == VIR_OFS_VEC_OFS);
    assign wr_vvr  = reg_req.wr && (reg_req.addr == VIR_OFS_VEC_DEST);
    assign wr_rar  = reg_req.wr && (reg_req.addr == VIR_OFS_SWAP_RAM);

    // page address select by configured page size; code 11 is undefined and treated as 4k
    always_comb begin
        unique case (page_size_code)
            VIR_PG_8K:  ram_addr_d = reg_req.wdata[VIR_PG8K_LSB +: VIR_RAM_AW];  // [R18]
            VIR_PG_512: ram_addr_d = reg_req.wdata[VIR_PG512_LSB +: VIR_RAM_AW]; // [R18]
            default:    ram_addr_d = reg_req.wdata[VIR_PG4K_LSB +: VIR_RAM_AW];  // [R18]
        endcase
    end

    // access port is a window onto the ram, nothing is stored here
    vir_page_ram #(
        .AW(VIR_RAM_AW)
    ) u_ram (
        .ref_clk    (ref_clk),
        .host_en    (wr_rar),                                  // [R15]
        .host_we    (reg_req.wdata[VIR_RAR_RW_BIT]),           // [R16]
        .host_addr  (ram_addr_d),
        .host_wdata (reg_req.wdata[2:0]),                      // [R16]
        .host_rdata (ram_host_rd),
        .look_en    (look_req),
        .look_addr  (look_page),
        .look_rdata (ram_look_rd)
    );

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lvl_cfg_q <= VIR_RST_WORD[4:0];
        end else if (wr_lvl) begin
            lvl_cfg_q <= reg_req.wdata[4:0] & VIR_LVL_CFG_MASK; // [R03]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            vofs_q <= VIR_RST_WORD[7:0];
            diag_q <= 1'b0;
            vdis_q <= 1'b0;
        end else if (wr_vofs) begin
            vofs_q <= reg_req.wdata[VIR_VOFS_LSB +: 8];
            diag_q <= reg_req.wdata[VIR_DIAG_BIT]; // [R09]
            vdis_q <= reg_req.wdata[VIR_VDIS_BIT]; // [R10]
        end
    end

    // a software set in the same cycle as the pass pulse wins, so a new suite is not lost
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fail_q <= 1'b0;
        end else if (wr_vofs && reg_req.wdata[VIR_FAIL_BIT]) begin
            fail_q <= 1'b1; // [R08]
        end else if (diag_all_passed) begin
            fail_q <= 1'b0; // [R08]
        end else if (wr_vofs) begin
            fail_q <= 1'b0;
        end
    end

    // host writes never reach the mask; only the internal bus does
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ibmask_q <= VIR_RST_WORD[3:0];
        end else if (internal_bus_mask_we) begin
            ibmask_q <= internal_bus_mask_wdata; // [R11]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            vvr_q <= VIR_RST_WORD;
        end else if (wr_vvr) begin
            vvr_q <= reg_req.wdata; // [R14]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            iack_vec_q[0] <= VIR_RST_WORD[7:0];
            iack_vec_q[1] <= VIR_RST_WORD[7:0];
            iack_vec_q[2] <= VIR_RST_WORD[7:0];
        end else if (iack_done && iack_level != 2'h3) begin
            iack_vec_q[iack_level] <= iack_vector;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ident_vector <= 16'h0000;
            ident_valid  <= 1'b0;
        end else begin
            ident_valid <= ident_req;
            if (ident_req) begin
                if (ident_own) begin
                    ident_vector <= {vvr_q[15:VIR_VEC_LSB], 2'h0}; // [R13]
                end else if (ident_level != 2'h3) begin
                    ident_vector <= {vofs_q, iack_vec_q[ident_level]}; // [R06]
                end else begin
                    ident_vector <= 16'h0000;
                end
            end
        end
    end

    // routing outputs registered; levels 1 and 2 line and priority fixed, the rest from the config bits
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lvl_brline         <= {VIR_BR4, VIR_BR4, VIR_BR4};
            lvl_priority_level <= {VIR_PRIO_BASE, VIR_PRIO_BASE, VIR_PRIO_BASE};
            lvl_rora           <= 3'h0;
        end else begin
            lvl_brline[2]         <= vir_brline_t'(lvl_cfg_q[VIR_LVL3_LSB+1 +: 2]); // [R01]
            lvl_priority_level[2] <= VIR_PRIO_BASE + {3'h0, lvl_cfg_q[VIR_LVL3_LSB+1 +: 2]}; // [R01]
            lvl_rora[2]           <= lvl_cfg_q[VIR_LVL3_LSB]; // [R02]
            lvl_brline[1]         <= VIR_BR4;       // [R04]
            lvl_priority_level[1] <= VIR_PRIO_BASE; // [R04]
            lvl_rora[1]           <= lvl_cfg_q[VIR_LVL2_BIT]; // [R03]
            lvl_brline[0]         <= VIR_BR4;       // [R05]
            lvl_priority_level[0] <= VIR_PRIO_BASE;
            lvl_rora[0]           <= lvl_cfg_q[VIR_LVL1_BIT]; // [R05]
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            interrupt_transaction_dest <= 16'h0000;
            loopback_en                <= 1'b0;
            vme_drv_disable            <= 1'b0;
        end else begin
            interrupt_transaction_dest <= vvr_q[VIR_DEST_LSB +: 16]; // [R12]
            loopback_en                <= diag_q; // [R09]
            vme_drv_disable            <= vdis_q; // [R10]
        end
    end

    // read mux; reserved bits of each register come back zero
    always_comb begin
        unique case (reg_req.addr)
            VIR_OFS_LVL_CFG:  rd_word_d = {27'h0, lvl_cfg_q};
            VIR_OFS_VEC_OFS:  rd_word_d = {16'h0, vofs_q, 1'b0, fail_q, diag_q, vdis_q, ibmask_q}; // [R07]
            VIR_OFS_VEC_DEST: rd_word_d = vvr_q; // [R14]
            VIR_OFS_SWAP_RAM: rd_word_d = {28'h0, ram_host_rd}; // [R19]
            default:          rd_word_d = 32'h0000_0000;
        endcase
    end

    // ram output holds the entry of the last applied address, so a bare read still answers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata  <= 32'h0000_0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd) begin
                reg_rdata <= rd_word_d; // [R23]
            end
        end
    end

    // vme page lookup, answered two cycles after the request
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            look_pend_q     <= 1'b0;
            look_valid      <= 1'b0;
            look_interlock  <= 1'b0;
            look_swap       <= VIR_SW_NONE;
            look_parity_err <= 1'b0;
        end else begin
            look_pend_q <= look_req;
            look_valid  <= look_pend_q;
            if (look_pend_q) begin
                look_interlock  <= ~ram_look_rd[2]; // [R21]
                look_swap       <= vir_swap_t'(ram_look_rd[1:0]); // [R22]
                look_parity_err <= ^ram_look_rd;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_lvl3_prio: assert property ($past(!rst) |-> lvl_priority_level[2] == VIR_PRIO_BASE + {3'h0, $past(lvl_cfg_q[4:3])}) // [R01]
        else $error("level 3 priority does not follow its select code");
    a_lvl3_type: assert property (wr_lvl |=> ##1 lvl_rora[2] == $past(reg_req.wdata[VIR_LVL3_LSB], 2)) // [R02]
        else $error("level 3 interrupter type wrong");
    a_lvl2_fixed: assert property (lvl_brline[1] == VIR_BR4 && lvl_priority_level[1] == VIR_PRIO_BASE) // [R04]
        else $error("level 2 routing not fixed");
    a_lvl1_type: assert property (wr_lvl |=> ##1 lvl_rora[0] == $past(reg_req.wdata[0], 2) && lvl_brline[0] == VIR_BR4) // [R05]
        else $error("level 1 type or line wrong");
    a_ident_vme: assert property (ident_req && !ident_own && ident_level == 2'h0 |=> ident_valid
                                   && ident_vector == {$past(vofs_q), $past(iack_vec_q[0])}) // [R06]
        else $error("vme identify vector not offset plus vector");
    a_vofs_resv: assert property (reg_rvalid && $past(reg_req.addr) == VIR_OFS_VEC_OFS |-> reg_rdata[31:16] == 16'h0000
                                   && !reg_rdata[7]) // [R07]
        else $error("offset register reserved bits not zero");
    a_fail_clear: assert property (diag_all_passed && !(wr_vofs && reg_req.wdata[VIR_FAIL_BIT]) |=> !fail_q) // [R08]
        else $error("test fail not cleared on pass");
    a_fail_set: assert property (wr_vofs && reg_req.wdata[VIR_FAIL_BIT] |=> fail_q) // [R08]
        else $error("test fail set lost");
    a_loopback: assert property (wr_vofs |=> ##1 loopback_en == $past(reg_req.wdata[VIR_DIAG_BIT], 2)) // [R09]
        else $error("loopback not following diagnostic bit");
    a_vme_disable: assert property (wr_vofs |=> ##1 vme_drv_disable == $past(reg_req.wdata[VIR_VDIS_BIT], 2)) // [R10]
        else $error("vme driver disable not following bit");
    a_mask_host: assert property (!internal_bus_mask_we |=> $stable(ibmask_q)) // [R11]
        else $error("internal bus mask changed without internal bus write");
    a_dest_mask: assert property (wr_vvr |=> ##1 interrupt_transaction_dest == $past(reg_req.wdata[31:16], 2)) // [R12]
        else $error("destination mask not applied");
    a_ident_own: assert property (ident_req && ident_own |=> ident_vector == {$past(vvr_q[15:2]), 2'h0}) // [R13]
        else $error("own identify vector wrong");
    a_rar_resv: assert property (reg_rvalid && $past(reg_req.addr) == VIR_OFS_SWAP_RAM |-> reg_rdata[31:4] == 28'h0) // [R19]
        else $error("access port reserved bits not zero");
    a_ram_parity: assert property (wr_rar && reg_req.wdata[VIR_RAR_RW_BIT] ##1 !wr_rar
                                    ##1 reg_req.rd && reg_req.addr == VIR_OFS_SWAP_RAM
                                    |=> reg_rdata[3:0] == {^$past(reg_req.wdata[2:0], 3), $past(reg_req.wdata[2:0], 3)}) // [R20]
        else $error("ram write readback or parity wrong");
    a_look_mode: assert property (look_pend_q |=> look_valid && look_interlock == ~$past(ram_look_rd[2])) // [R21]
        else $error("rmw mode lookup wrong");

    c_ram_write_read: cover property (wr_rar && reg_req.wdata[VIR_RAR_RW_BIT] ##2 reg_req.rd);
    c_ram_addr_read: cover property (wr_rar && !reg_req.wdata[VIR_RAR_RW_BIT] ##2 reg_req.rd);
    c_ident_both: cover property (ident_req && ident_own ##[1:8] ident_req && !ident_own);
    c_fail_cycle: cover property (fail_q ##[1:20] !fail_q);
endmodule

// ---- tb/vir_vme_irq_model.sv ----
// vme interrupter model: answers an acknowledge cycle with its own vector
`timescale 1ns/100ps
module vir_vme_irq_model (
    // clock
    input  wire logic       ref_clk,
    // command from the bench
    input  wire logic       ack_go,
    input  wire logic [1:0] ack_lvl,
    input  wire logic [7:0] ack_vec,
    // acknowledge result toward the register bank
    output logic            iack_done,
    output logic [1:0]      iack_level,
    output logic [7:0]      iack_vector
);
    // outside an acknowledge the lines flip so no stale vector can be mistaken for a fresh one
    initial begin
        iack_done   = 1'b0;
        iack_level  = 2'h3;
        iack_vector = 8'h00;
        forever begin
            @(posedge ref_clk);
            iack_done   <= ack_go;
            iack_level  <= ack_go ? ack_lvl : ~iack_level;
            iack_vector <= ack_go ? ack_vec : ~iack_vector;
        end
    end
endmodule

// ---- tb/test_vme_interrupt_vector_swap_ram_regs.sv ----
// self-checking bench for the interrupt vector and swap ram register bank
`timescale 1ns/100ps
module test_vme_interrupt_vector_swap_ram_regs
    import vir_pkg::*;
;
    logic ref_clk, rst, reg_rvalid, internal_bus_mask_we, diag_all_passed, iack_done, ack_go;
    logic ident_req, ident_own, ident_valid, loopback_en, vme_drv_disable;
    logic look_req, look_valid, look_interlock, look_parity_err;
    logic [1:0] page_size_code, iack_level, ack_lvl, ident_level;
    logic [3:0] internal_bus_mask_wdata;
    logic [7:0] iack_vector, ack_vec;
    logic [15:0] ident_vector, interrupt_transaction_dest, look_page;
    logic [31:0] reg_rdata, rv;
    logic [2:0][4:0] lvl_priority_level;
    logic [2:0] lvl_rora;
    vir_brline_t [2:0] lvl_brline;
    vir_swap_t look_swap;
    vir_reg_req_t req;
    int n_errors, compares, lsb;

    vir_regs i_vir_regs (
        .ref_clk(ref_clk), .rst(rst), .reg_req(req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .internal_bus_mask_we(internal_bus_mask_we), .internal_bus_mask_wdata(internal_bus_mask_wdata),
        .diag_all_passed(diag_all_passed), .page_size_code(page_size_code),
        .iack_done(iack_done), .iack_level(iack_level), .iack_vector(iack_vector),
        .ident_req(ident_req), .ident_own(ident_own), .ident_level(ident_level),
        .ident_vector(ident_vector), .ident_valid(ident_valid), .lvl_brline(lvl_brline),
        .lvl_priority_level(lvl_priority_level), .lvl_rora(lvl_rora),
        .interrupt_transaction_dest(interrupt_transaction_dest), .loopback_en(loopback_en),
        .vme_drv_disable(vme_drv_disable), .look_req(look_req), .look_page(look_page),
        .look_valid(look_valid), .look_interlock(look_interlock), .look_swap(look_swap),
        .look_parity_err(look_parity_err)
    );
    vir_vme_irq_model i_vir_vme_irq_model (
        .ref_clk(ref_clk), .ack_go(ack_go), .ack_lvl(ack_lvl), .ack_vec(ack_vec),
        .iack_done(iack_done), .iack_level(iack_level), .iack_vector(iack_vector)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask
    // bounded wait on one of the answer strobes: 0 read, 1 identify, 2 lookup
    task automatic wait_hi(input int w);
        int n;
        n = 0;
        while (((w == 0) ? reg_rvalid : (w == 1) ? ident_valid : look_valid) !== 1'b1 && n < 4) begin
            tick();
            n++;
        end
        if (n == 4) begin
            n_errors++;
            $display("wrong value at %0t: no answer", $time);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        tick();
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        tick();
        req.wr = 1'b0;
        req.wdata = ~d;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        tick();
        req.rd = 1'b1;
        req.addr = a;
        tick();
        req.rd = 1'b0;
        wait_hi(0);
        chk(reg_rdata, exp);
    endtask
    task automatic ident(input logic own, input logic [1:0] lvl, input logic [15:0] exp);
        tick();
        ident_req = 1'b1;
        ident_own = own;
        ident_level = lvl;
        tick();
        ident_req = 1'b0;
        wait_hi(1);
        chk({16'h0, ident_vector}, {16'h0, exp});
    endtask
    task automatic iack(input logic [1:0] lvl, input logic [7:0] v);
        tick();
        ack_go = 1'b1;
        ack_lvl = lvl;
        ack_vec = v;
        tick();
        ack_go = 1'b0;
        tick();
    endtask
    task automatic look(input logic [15:0] p, input logic [31:0] exp);
        tick();
        look_req = 1'b1;
        look_page = p;
        tick();
        look_req = 1'b0;
        look_page = ~p;
        wait_hi(2);
        chk({28'h0, look_parity_err, look_interlock, look_swap}, exp);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        #200000;
        n_errors++;
        results();
    end
    initial begin
        n_errors = 0;
        compares = 0;
        rst = 1'b1;
        req = '0;
        {internal_bus_mask_we, internal_bus_mask_wdata, diag_all_passed, page_size_code} = '0;
        {ack_go, ack_lvl, ack_vec, ident_req, ident_own, ident_level, look_req, look_page} = '0;
        repeat (20) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        rdchk(VIR_OFS_LVL_CFG, 32'h0);
        rdchk(VIR_OFS_VEC_OFS, 32'h0);
        rdchk(VIR_OFS_VEC_DEST, 32'h0);
        chk({31'h0, loopback_en}, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wr(VIR_OFS_LVL_CFG, {27'h0, i[2:0], i[0], ~i[0]});
            repeat (2) tick();
            chk({30'h0, lvl_brline[2]}, {30'h0, i[2:1]});
            chk({27'h0, lvl_priority_level[2]}, {27'h0, VIR_PRIO_BASE + 5'(i[2:1])});
            chk({29'h0, lvl_rora}, {29'h0, i[0], i[0], ~i[0]});
            chk({18'h0, lvl_brline[1:0], lvl_priority_level[1:0]}, {22'h0, VIR_PRIO_BASE, VIR_PRIO_BASE});
            rdchk(VIR_OFS_LVL_CFG, {27'h0, i[2:0], i[0], ~i[0]});
        end
        wr(VIR_OFS_VEC_OFS, 32'hFFFF_FFFF);
        repeat (2) tick();
        chk({30'h0, loopback_en, vme_drv_disable}, 32'h3);
        rdchk(VIR_OFS_VEC_OFS, 32'h0000_FF70);
        tick();
        internal_bus_mask_we = 1'b1;
        internal_bus_mask_wdata = 4'hA;
        tick();
        internal_bus_mask_we = 1'b0;
        rdchk(VIR_OFS_VEC_OFS, 32'h0000_FF7A);
        tick();
        diag_all_passed = 1'b1;
        tick();
        diag_all_passed = 1'b0;
        rdchk(VIR_OFS_VEC_OFS, 32'h0000_FF3A);
        wr(VIR_OFS_VEC_OFS, 32'h0000_5C40);
        repeat (2) tick();
        chk({30'h0, loopback_en, vme_drv_disable}, 32'h0);
        rdchk(VIR_OFS_VEC_OFS, 32'h0000_5C4A);
        wr(VIR_OFS_VEC_DEST, 32'hA5C3_1237);
        repeat (2) tick();
        chk({16'h0, interrupt_transaction_dest}, 32'h0000_A5C3);
        rdchk(VIR_OFS_VEC_DEST, 32'hA5C3_1237);
        ident(1'b1, 2'h0, 16'h1234);
        iack(2'h0, 8'h9E);
        iack(2'h1, 8'h27);
        ident(1'b0, 2'h0, 16'h5C9E);
        ident(1'b0, 2'h1, 16'h5C27);
        ident(1'b1, 2'h1, 16'h1234);
        // pages 1 and 2 per size; a wrong address slice aliases them or misses
        for (int s = 0; s < 3; s++) begin
            page_size_code = 2'(s);
            lsb = (s == 0) ? VIR_PG4K_LSB : (s == 1) ? VIR_PG8K_LSB : VIR_PG512_LSB;
            wr(VIR_OFS_SWAP_RAM, (32'h1 << lsb) | 32'hE000_01F0 | 32'(s + 1));
            wr(VIR_OFS_SWAP_RAM, (32'h2 << lsb) | 32'h10 | 32'(6 - s));
            rdchk(VIR_OFS_SWAP_RAM, {28'h0, ^3'(6 - s), 3'(6 - s)});
            wr(VIR_OFS_SWAP_RAM, (32'h1 << lsb) | 32'h7);
            rdchk(VIR_OFS_SWAP_RAM, {28'h0, ^3'(s + 1), 3'(s + 1)});
            rdchk(VIR_OFS_SWAP_RAM, {28'h0, ^3'(s + 1), 3'(s + 1)});
            wr(VIR_OFS_SWAP_RAM, 32'h2 << lsb);
            rdchk(VIR_OFS_SWAP_RAM, {28'h0, ^3'(6 - s), 3'(6 - s)});
        end
        page_size_code = VIR_PG_4K;
        for (int k = 0; k < 8; k++) begin
            wr(VIR_OFS_SWAP_RAM, (32'(k + 16) << VIR_PG4K_LSB) | 32'h10 | 32'(k));
        end
        for (int k = 0; k < 8; k++) begin
            look(16'(k + 16), {29'h0, ~k[2], k[1:0]});
        end
        // second reset in mid-run: registers and routing must fall back to their reset values
        rst = 1'b1;
        repeat (2) tick();
        rst = 1'b0;
        rdchk(VIR_OFS_VEC_OFS, 32'h0);
        rdchk(VIR_OFS_VEC_DEST, 32'h0);
        chk({16'h0, interrupt_transaction_dest}, 32'h0);
        chk({27'h0, lvl_priority_level[2]}, {27'h0, VIR_PRIO_BASE});
        results();
    end
endmodule
